// [gb_consts.svh]
// register offsets, reset values, field positions and timing counts of the port block
`ifndef GB_CONSTS_SVH
`define GB_CONSTS_SVH

// register byte offsets
`define GB_OFF_CTRL 12'h180
`define GB_OFF_MF_DOUT 12'h184
`define GB_OFF_MF_DIR 12'h188
`define GB_OFF_MF_DIN 12'h18c
`define GB_OFF_MF_SEL 12'h190
`define GB_OFF_IO_PD 12'h194
`define GB_OFF_MF_PD 12'h198
`define GB_OFF_ST_MF_RISE 12'h19c
`define GB_OFF_ST_MF_FALL 12'h1a0
`define GB_OFF_ST_IO 12'h1a4
`define GB_OFF_MK_MF_RISE 12'h1a8
`define GB_OFF_MK_MF_FALL 12'h1ac
`define GB_OFF_MK_IO 12'h1b0

// control word field positions (low bit of each 7-bit field)
`define GB_CTRL_DIN_LSB 0
`define GB_CTRL_DOUT_LSB 8
`define GB_CTRL_DIR_LSB 16
`define GB_CTRL_DEB_LSB 24

// dedicated pin event status layout
`define GB_ST_IO_RISE_LSB 0
`define GB_ST_IO_FALL_LSB 8

// reset values
`define GB_RST_IO_DIR 7'h00
`define GB_RST_IO_DOUT 7'h00
`define GB_RST_IO_DEB 7'h00
`define GB_RST_MF_DOUT 32'h00000000
`define GB_RST_MF_DIR 32'h00000000
`define GB_RST_MF_SEL 32'hf20f0fff
`define GB_RST_IO_PD 7'h7f
`define GB_RST_MF_PD 32'hfaf03ffc

// debounce timing: a level must hold this long to pass the filter
`define GB_CLK_MHZ 40
`define GB_DEB_TIME_NS 100000
`define GB_DEB_CYCLES ((`GB_DEB_TIME_NS * `GB_CLK_MHZ) / 1000)
`define GB_DEB_CNT_W 12

`endif

// [gb_pkg.sv]
// types shared by the port block
package gb_pkg;

    // wishbone request from the master
    typedef struct packed {
        logic [11:0] adr;
        logic [31:0] dat;
        logic [3:0]  sel;
        logic        we;
    } gb_wb_req_t;

    // dedicated bank pad drive
    typedef struct packed {
        logic [6:0] dout;
        logic [6:0] oe;
        logic [6:0] pull;
    } gb_io_pad_t;

    // multi-function bank pad drive
    typedef struct packed {
        logic [31:0] dout;
        logic [31:0] oe;
        logic [31:0] pull;
    } gb_mf_pad_t;

endpackage

// [gb_debounce.sv]
// per-bit debounce filter with bypass for the dedicated pins
`timescale 1ns/10ps
`include "gb_consts.svh"
module gb_debounce
    import gb_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // levels
    input  wire logic [6:0] raw_i,
    input  wire logic [6:0] en_i,
    output logic [6:0]      level_o
);

    localparam logic [`GB_DEB_CNT_W-1:0] DEB_MAX = `GB_DEB_CNT_W'(`GB_DEB_CYCLES - 1);

    logic [6:0] filt_q;
    logic [`GB_DEB_CNT_W-1:0] cnt_q [7];

    // a bit follows the raw level only after it has differed for the whole window
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < 7; i++) begin
            if (rst_i) begin
                filt_q[i] <= 1'b0;
                cnt_q[i] <= '0;
            end else if (raw_i[i] == filt_q[i]) begin
                cnt_q[i] <= '0;
            end else if (cnt_q[i] == DEB_MAX) begin
                filt_q[i] <= raw_i[i];
                cnt_q[i] <= '0;
            end else begin
                cnt_q[i] <= cnt_q[i] + 1'b1;
            end
        end
    end

    // bypass keeps filter state running so switching modes is glitch-limited
    assign level_o = (en_i & filt_q) | (~en_i & raw_i);

endmodule

// [gb_gpio.sv]
// two-bank general purpose port with edge events and wishbone register access
`timescale 1ns/10ps
`include "gb_consts.svh"
// Overview of operation
// - each multi-function pin rising edge sets its own sticky bit in status three
// - each multi-function pin falling edge sets its own sticky bit in status four
// - each dedicated pin sets own rise and fall bits in status five
// - debounce select one filters a dedicated pin input, zero bypasses filter
// - dedicated direction bit one makes output, zero input; resets to zero
// - dedicated pin driven from output bit only while set as output
// - dedicated input bits read the pin level in either direction
// - multi-function pin driven from output register only while set as output
// - multi-function direction one is output, zero input; resets to zero
// - multi-function input register reads pin level whatever the direction
// - select one gives pin to port logic, zero keeps normal function
// - dedicated power-down bit one lets pin power down; zero keeps active
// - multi-function power-down bit one lets pin power down; zero keeps active
// - in power-down, set bit pulls pin low; clear bit floats or drives
module gb_gpio
    import gb_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire gb_wb_req_t  wb_req_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // chip power-down state
    input  wire logic        powerdown_i,
    // dedicated pins
    input  wire logic [6:0]  io_pin_i,
    output gb_io_pad_t       io_pad_o,
    // multi-function pins
    input  wire logic [31:0] mf_pin_i,
    output gb_mf_pad_t       mf_pad_o,
    // normal pin functions sharing the multi-function pins
    input  wire logic [31:0] func_dout_i,
    input  wire logic [31:0] func_oe_i,
    output logic [31:0]      func_din_o,
    // interrupt
    output logic             irq_o
);

    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old_v & ~m) | (new_v & m);
    endfunction

    // sticky status update: a set in the clearing cycle wins
    function automatic logic [31:0] sticky(input logic [31:0] old_v, input logic [31:0] set_v,
                                           input logic [31:0] clr_v);
        return (old_v & ~clr_v) | set_v;
    endfunction

    // registers
    logic [6:0] io_dir_q;
    logic [6:0] io_dout_q;
    logic [6:0] io_deb_q;
    logic [6:0] io_pd_q;
    logic [31:0] mf_dout_q;
    logic [31:0] mf_dir_q;
    logic [31:0] mf_sel_q;
    logic [31:0] mf_pd_q;
    logic [31:0] st_mf_rise_q;
    logic [31:0] st_mf_fall_q;
    logic [31:0] st_io_q;
    logic [31:0] mk_mf_rise_q;
    logic [31:0] mk_mf_fall_q;
    logic [31:0] mk_io_q;
    logic [31:0] wb_dat_q;
    logic wb_ack_q;
    logic irq_q;

    // synchronisers and edge history
    logic [6:0] io_s1_q;
    logic [6:0] io_s2_q;
    logic [31:0] mf_s1_q;
    logic [31:0] mf_s2_q;
    logic [6:0] io_prev_q;
    logic [31:0] mf_prev_q;
    logic [6:0] io_level;

    // pad and function outputs
    gb_io_pad_t io_pad_q;
    gb_mf_pad_t mf_pad_q;
    logic [31:0] func_din_q;

    // two flip-flops on every pin before anything looks at it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            io_s1_q <= 7'h00;
            io_s2_q <= 7'h00;
            mf_s1_q <= 32'h00000000;
            mf_s2_q <= 32'h00000000;
        end else begin
            io_s1_q <= io_pin_i;
            io_s2_q <= io_s1_q;
            mf_s1_q <= mf_pin_i;
            mf_s2_q <= mf_s1_q;
        end
    end

    // dedicated pin debounce
    gb_debounce u_deb (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .raw_i   (io_s2_q),
        .en_i    (io_deb_q),
        .level_o (io_level)
    );

    // bus decode
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_q;
    wire bus_wr = bus_req & wb_req_i.we;
    wire [11:0] adr_w = {wb_req_i.adr[11:2], 2'b00};
    wire hit_ctrl = adr_w == `GB_OFF_CTRL;
    wire hit_mf_dout = adr_w == `GB_OFF_MF_DOUT;
    wire hit_mf_dir = adr_w == `GB_OFF_MF_DIR;
    wire hit_mf_din = adr_w == `GB_OFF_MF_DIN;
    wire hit_mf_sel = adr_w == `GB_OFF_MF_SEL;
    wire hit_io_pd = adr_w == `GB_OFF_IO_PD;
    wire hit_mf_pd = adr_w == `GB_OFF_MF_PD;
    wire hit_st_mr = adr_w == `GB_OFF_ST_MF_RISE;
    wire hit_st_mf = adr_w == `GB_OFF_ST_MF_FALL;
    wire hit_st_io = adr_w == `GB_OFF_ST_IO;
    wire hit_mk_mr = adr_w == `GB_OFF_MK_MF_RISE;
    wire hit_mk_mf = adr_w == `GB_OFF_MK_MF_FALL;
    wire hit_mk_io = adr_w == `GB_OFF_MK_IO;

    // current stored words, used for reads and for byte-lane merges
    wire [31:0] ctrl_word = {1'b0, io_deb_q, 1'b0, io_dir_q, 1'b0, io_dout_q, 1'b0, io_s2_q};
    wire [31:0] ctrl_new = lane_merge(ctrl_word, wb_req_i.dat, wb_req_i.sel);
    wire [31:0] io_pd_new = lane_merge({25'h0000000, io_pd_q}, wb_req_i.dat, wb_req_i.sel);
    wire [31:0] wr_mask = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}}, {8{wb_req_i.sel[1]}},
                           {8{wb_req_i.sel[0]}}};
    wire [31:0] clr_data = wb_req_i.dat & wr_mask;

    // read mux; unmapped offsets read as zero
    wire [31:0] rd_data =
        hit_ctrl ? ctrl_word :
        hit_mf_dout ? mf_dout_q :
        hit_mf_dir ? mf_dir_q :
        hit_mf_din ? mf_s2_q :
        hit_mf_sel ? mf_sel_q :
        hit_io_pd ? {25'h0000000, io_pd_q} :
        hit_mf_pd ? mf_pd_q :
        hit_st_mr ? st_mf_rise_q :
        hit_st_mf ? st_mf_fall_q :
        hit_st_io ? st_io_q :
        hit_mk_mr ? mk_mf_rise_q :
        hit_mk_mf ? mk_mf_fall_q :
        hit_mk_io ? mk_io_q :
        32'h00000000;

    // edge events on synchronised (and for the dedicated bank, filtered) levels
    wire [31:0] mf_rise = mf_s2_q & ~mf_prev_q;
    wire [31:0] mf_fall = ~mf_s2_q & mf_prev_q;
    wire [6:0] io_rise = io_level & ~io_prev_q;
    wire [6:0] io_fall = ~io_level & io_prev_q;
    wire [31:0] io_set = {17'h00000, io_fall, 1'b0, io_rise};

    // write-one-to-clear strobes
    wire [31:0] clr_mr = (bus_wr & hit_st_mr) ? clr_data : 32'h00000000;
    wire [31:0] clr_mf = (bus_wr & hit_st_mf) ? clr_data : 32'h00000000;
    wire [31:0] clr_io = (bus_wr & hit_st_io) ? clr_data : 32'h00000000;

    // edge history; reset to the current level is not possible, so the first
    // sample after reset may report a rise on a pin that is already high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mf_prev_q <= 32'h00000000;
            io_prev_q <= 7'h00;
        end else begin
            mf_prev_q <= mf_s2_q;
            io_prev_q <= io_level;
        end
    end

    // sticky event status
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_mf_rise_q <= 32'h00000000;
            st_mf_fall_q <= 32'h00000000;
            st_io_q <= 32'h00000000;
        end else begin
            st_mf_rise_q <= sticky(st_mf_rise_q, mf_rise, clr_mr);
            st_mf_fall_q <= sticky(st_mf_fall_q, mf_fall, clr_mf);
            st_io_q <= sticky(st_io_q, io_set, clr_io);
        end
    end

    // dedicated bank configuration
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            io_dir_q <= `GB_RST_IO_DIR;
            io_dout_q <= `GB_RST_IO_DOUT;
            io_deb_q <= `GB_RST_IO_DEB;
            io_pd_q <= `GB_RST_IO_PD;
        end else if (bus_wr) begin
            if (hit_ctrl) begin
                io_dir_q <= ctrl_new[`GB_CTRL_DIR_LSB +: 7];
                io_dout_q <= ctrl_new[`GB_CTRL_DOUT_LSB +: 7];
                io_deb_q <= ctrl_new[`GB_CTRL_DEB_LSB +: 7];
            end
            if (hit_io_pd) begin
                io_pd_q <= io_pd_new[6:0];
            end
        end
    end

    // multi-function bank configuration
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mf_dout_q <= `GB_RST_MF_DOUT;
            mf_dir_q <= `GB_RST_MF_DIR;
            mf_sel_q <= `GB_RST_MF_SEL;
            mf_pd_q <= `GB_RST_MF_PD;
        end else if (bus_wr) begin
            if (hit_mf_dout) begin
                mf_dout_q <= lane_merge(mf_dout_q, wb_req_i.dat, wb_req_i.sel);
            end
            if (hit_mf_dir) begin
                mf_dir_q <= lane_merge(mf_dir_q, wb_req_i.dat, wb_req_i.sel);
            end
            if (hit_mf_sel) begin
                mf_sel_q <= lane_merge(mf_sel_q, wb_req_i.dat, wb_req_i.sel);
            end
            if (hit_mf_pd) begin
                mf_pd_q <= lane_merge(mf_pd_q, wb_req_i.dat, wb_req_i.sel);
            end
        end
    end

    // interrupt masks share the status layout
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mk_mf_rise_q <= 32'h00000000;
            mk_mf_fall_q <= 32'h00000000;
            mk_io_q <= 32'h00000000;
        end else if (bus_wr) begin
            if (hit_mk_mr) begin
                mk_mf_rise_q <= lane_merge(mk_mf_rise_q, wb_req_i.dat, wb_req_i.sel);
            end
            if (hit_mk_mf) begin
                mk_mf_fall_q <= lane_merge(mk_mf_fall_q, wb_req_i.dat, wb_req_i.sel);
            end
            if (hit_mk_io) begin
                mk_io_q <= lane_merge(mk_io_q, wb_req_i.dat, wb_req_i.sel);
            end
        end
    end

    // one ack per request, one cycle after it is seen; ack drops next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_q <= 1'b0;
            wb_dat_q <= 32'h00000000;
        end else begin
            wb_ack_q <= bus_req;
            wb_dat_q <= (bus_req & ~wb_req_i.we) ? rd_data : 32'h00000000;
        end
    end

    // level interrupt, registered so the output comes from a flip-flop
    wire irq_d = |(st_mf_rise_q & mk_mf_rise_q) | |(st_mf_fall_q & mk_mf_fall_q) |
                 |(st_io_q & mk_io_q);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    // dedicated pads: power-down with bit set pulls low, else per direction
    wire [6:0] io_pd_act = powerdown_i ? io_pd_q : 7'h00;
    wire [6:0] io_oe_d = io_dir_q & ~io_pd_act;

    // multi-function pads: port logic owns the pin only when selected
    wire [31:0] mf_pd_act = powerdown_i ? mf_pd_q : 32'h00000000;
    wire [31:0] mf_oe_sel = (mf_sel_q & mf_dir_q) | (~mf_sel_q & func_oe_i);
    wire [31:0] mf_dout_sel = (mf_sel_q & mf_dout_q) | (~mf_sel_q & func_dout_i);
    wire [31:0] mf_oe_d = mf_oe_sel & ~mf_pd_act;

    // pad drive registers; one cycle behind configuration and the normal function
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            io_pad_q <= '0;
            mf_pad_q <= '0;
            func_din_q <= 32'h00000000;
        end else begin
            io_pad_q.dout <= io_dout_q & io_oe_d;
            io_pad_q.oe <= io_oe_d;
            io_pad_q.pull <= io_pd_act;
            mf_pad_q.dout <= mf_dout_sel & mf_oe_d;
            mf_pad_q.oe <= mf_oe_d;
            mf_pad_q.pull <= mf_pd_act;
            func_din_q <= mf_s2_q & ~mf_sel_q;
        end
    end

    // outputs
    assign wb_dat_o = wb_dat_q;
    assign wb_ack_o = wb_ack_q;
    assign irq_o = irq_q;
    assign io_pad_o = io_pad_q;
    assign mf_pad_o = mf_pad_q;
    assign func_din_o = func_din_q;

endmodule

// [gb_gpio_assertions.sv]
// concurrent checks on the port block pins and bus answer
`timescale 1ns/10ps
module gb_gpio_assertions
    import gb_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // pads
    input wire logic powerdown_i,
    input wire gb_io_pad_t io_pad_o,
    input wire gb_mf_pad_t mf_pad_o
);
    // one domain, so one clock and one reset for all
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // a request is answered in exactly one cycle, once
    ack_one_cycle_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    ack_single_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    dat_idle_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    // a pin not driven shows no drive value
    io_dout_gated_a: assert property ((io_pad_o.dout & ~io_pad_o.oe) == 7'h00)
        else $error("dedicated pad value without enable");
    mf_dout_gated_a: assert property ((mf_pad_o.dout & ~mf_pad_o.oe) == 32'h0)
        else $error("multi pad value without enable");
    // pull-down only follows a power-down, and never fights a driver while the chip stays awake
    io_pull_pd_a: assert property (io_pad_o.pull != 7'h00 |-> $past(powerdown_i))
        else $error("dedicated pull outside power-down");
    mf_pull_pd_a: assert property (mf_pad_o.pull != 32'h0 |-> $past(powerdown_i))
        else $error("multi pull outside power-down");
    pull_not_drive_a: assert property (!powerdown_i ##1 !powerdown_i |->
        io_pad_o.pull == 7'h00 && (mf_pad_o.pull & mf_pad_o.oe) == 32'h0)
        else $error("pull active while awake");
endmodule

bind gb_gpio gb_gpio_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .powerdown_i(powerdown_i),
    .io_pad_o(io_pad_o), .mf_pad_o(mf_pad_o));

// [gb_pin_model.sv]
// board side of one pin bank: pads, pull-downs and external drivers
`timescale 1ns/10ps
module gb_pin_model #(
    parameter int W = 7
) (
    // clock
    input wire logic clk_i,
    // pad drive
    input wire logic [W-1:0] dout_i,
    input wire logic [W-1:0] oe_i,
    input wire logic [W-1:0] pull_i,
    // board drivers
    input wire logic [W-1:0] drv_i,
    input wire logic [W-1:0] drv_en_i,
    output logic [W-1:0] pin_o
);
    logic [W-1:0] last_q = '0;
    // pad wins, then pull-down, then board; a floating pin toggles so no value is trusted
    assign pin_o = (oe_i & dout_i) | (~oe_i & ~pull_i & drv_en_i & drv_i)
        | (~oe_i & ~pull_i & ~drv_en_i & ~last_q);
    always @(posedge clk_i) begin
        last_q <= pin_o;
    end
endmodule

// [gb_gpio_test.sv]
// self-checking bench for the two-bank port block
`timescale 1ns/10ps
`include "gb_consts.svh"
module gb_gpio_test
    import gb_pkg::*;
;
    logic clk_i = 0;
    logic rst_i = 1;
    logic cyc = 0;
    logic stb = 0;
    gb_wb_req_t req = '0;
    logic pd = 0;
    logic [31:0] fdo = 32'hffffffff;
    logic [31:0] foe = 32'hffffffff;
    logic [6:0] io_drv = 7'h00;
    logic [31:0] mf_drv = 32'h0;
    logic [31:0] wb_dat_o, func_din_o, mf_pin;
    logic wb_ack_o, irq_o;
    logic [6:0] io_pin;
    gb_io_pad_t io_pad_o;
    gb_mf_pad_t mf_pad_o;
    int failures = 0;
    int checks_done = 0;

    // 40 MHz
    always #12.5 clk_i = ~clk_i;

    gb_gpio uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_req_i(req),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .powerdown_i(pd), .io_pin_i(io_pin),
        .io_pad_o(io_pad_o), .mf_pin_i(mf_pin), .mf_pad_o(mf_pad_o), .func_dout_i(fdo),
        .func_oe_i(foe), .func_din_o(func_din_o), .irq_o(irq_o));
    gb_pin_model #(.W(7)) io_board (.clk_i(clk_i), .dout_i(io_pad_o.dout), .oe_i(io_pad_o.oe),
        .pull_i(io_pad_o.pull), .drv_i(io_drv), .drv_en_i(7'h7f), .pin_o(io_pin));
    gb_pin_model #(.W(32)) mf_board (.clk_i(clk_i), .dout_i(mf_pad_o.dout), .oe_i(mf_pad_o.oe),
        .pull_i(mf_pad_o.pull), .drv_i(mf_drv), .drv_en_i(32'hffffffff), .pin_o(mf_pin));

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask

    // one classic cycle, held until ack, then one idle cycle
    task automatic xfer(input logic we, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1;
        stb <= 1;
        req <= '{adr: a, dat: d, sel: 4'hf, we: we};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        cyc <= 0;
        stb <= 0;
        if (n >= 50) begin
            failures++;
            summarize();
        end
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1, a, d, q);
    endtask

    task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        xfer(0, a, 32'h0, q);
        check(name, q, exp);
    endtask

    task automatic cyc_wait(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic t_reset;
        rd_chk("dir", `GB_OFF_MF_DIR, 32'h0);
        rd_chk("sel", `GB_OFF_MF_SEL, 32'hf20f0fff);
        rd_chk("iopd", `GB_OFF_IO_PD, 32'h7f);
        rd_chk("mfpd", `GB_OFF_MF_PD, 32'hfaf03ffc);
        rd_chk("ctrl", `GB_OFF_CTRL, 32'h0);
        rd_chk("unmapped", 12'h1fc, 32'h0);
        check("mf oe rst", mf_pad_o.oe, 32'h0df0f000);
    endtask

    // selected pins follow the port, pin 0 stays with its normal function
    task automatic t_mf;
        wr(`GB_OFF_MF_SEL, 32'hfffffffe);
        wr(`GB_OFF_MF_DOUT, 32'ha5a5a5a4);
        wr(`GB_OFF_MF_DIR, 32'h0000fffe);
        wr(`GB_OFF_MF_DIN, 32'hffffffff);
        mf_drv <= 32'h5a5a0000;
        cyc_wait(6);
        check("mf oe", mf_pad_o.oe, 32'h0000ffff);
        check("mf dout", mf_pad_o.dout, 32'h0000a5a5);
        check("mf func", func_din_o, 32'h00000001);
        rd_chk("mf din", `GB_OFF_MF_DIN, 32'h5a5aa5a5);
    endtask

    task automatic t_io;
        io_drv <= 7'h30;
        wr(`GB_OFF_CTRL, 32'h000f557f);
        cyc_wait(6);
        check("io oe", io_pad_o.oe, 7'h0f);
        check("io dout", io_pad_o.dout, 7'h05);
        rd_chk("io ctrl", `GB_OFF_CTRL, 32'h000f5535);
    endtask

    task automatic t_events;
        wr(`GB_OFF_CTRL, 32'h0);
        wr(`GB_OFF_MF_DIR, 32'h0);
        // release pin 0 from its normal function so the board can move it
        foe <= 32'h0;
        mf_drv <= 32'h0;
        cyc_wait(8);
        wr(`GB_OFF_ST_MF_RISE, 32'hffffffff);
        wr(`GB_OFF_ST_MF_FALL, 32'hffffffff);
        wr(`GB_OFF_ST_IO, 32'hffffffff);
        wr(`GB_OFF_MK_MF_RISE, 32'h1);
        check("irq idle", irq_o, 1'b0);
        mf_drv <= 32'h1;
        cyc_wait(8);
        rd_chk("rise", `GB_OFF_ST_MF_RISE, 32'h1);
        rd_chk("no fall", `GB_OFF_ST_MF_FALL, 32'h0);
        check("irq set", irq_o, 1'b1);
        mf_drv <= 32'h0;
        cyc_wait(8);
        rd_chk("fall", `GB_OFF_ST_MF_FALL, 32'h1);
        rd_chk("sticky", `GB_OFF_ST_MF_RISE, 32'h1);
        wr(`GB_OFF_ST_MF_RISE, 32'h1);
        cyc_wait(4);
        check("irq masked", irq_o, 1'b0);
        io_drv <= 7'h31;
        cyc_wait(8);
        io_drv <= 7'h30;
        cyc_wait(8);
        rd_chk("io edges", `GB_OFF_ST_IO, 32'h101);
        wr(`GB_OFF_MK_IO, 32'h100);
        cyc_wait(2);
        check("irq io", irq_o, 1'b1);
        wr(`GB_OFF_ST_IO, 32'h101);
        cyc_wait(3);
        check("irq io clr", irq_o, 1'b0);
    endtask

    // a short glitch is filtered, a long level passes after the hold time
    task automatic t_debounce;
        wr(`GB_OFF_CTRL, 32'h02000000);
        wr(`GB_OFF_ST_IO, 32'hffffffff);
        io_drv <= 7'h32;
        cyc_wait(100);
        io_drv <= 7'h30;
        cyc_wait(10);
        rd_chk("glitch", `GB_OFF_ST_IO, 32'h0);
        io_drv <= 7'h32;
        cyc_wait(`GB_DEB_CYCLES - 20);
        rd_chk("early", `GB_OFF_ST_IO, 32'h0);
        cyc_wait(40);
        rd_chk("held", `GB_OFF_ST_IO, 32'h2);
    endtask

    task automatic t_powerdown;
        wr(`GB_OFF_CTRL, 32'h000f0000);
        pd <= 1;
        cyc_wait(3);
        check("io pull", io_pad_o.pull, 7'h7f);
        check("io off", io_pad_o.oe, 7'h00);
        check("mf pull", mf_pad_o.pull, 32'hfaf03ffc);
        wr(`GB_OFF_IO_PD, 32'h1);
        cyc_wait(3);
        check("io pull1", io_pad_o.pull, 7'h01);
        check("io keep", io_pad_o.oe, 7'h0e);
        pd <= 0;
        cyc_wait(3);
        check("io awake", io_pad_o.oe, 7'h0f);
    endtask

    initial begin
        cyc_wait(12);
        rst_i <= 0;
        @(posedge clk_i);
        t_reset();
        t_mf();
        t_io();
        t_events();
        t_debounce();
        t_powerdown();
        summarize();
    end
endmodule
